// [src/dbgx_map.svh]
`ifndef DBGX_MAP_SVH
`define DBGX_MAP_SVH

// Register byte offsets
`define DBGX_OFF_STATUS      12'h000
`define DBGX_OFF_IRQ_STAT    12'h004
`define DBGX_OFF_IRQ_MASK    12'h008
`define DBGX_OFF_CTRL        12'h00C
`define DBGX_OFF_BP_ADDR0    12'h010
`define DBGX_OFF_BP_CFG      12'h020
`define DBGX_OFF_LAST_EXC    12'h024

// Status word field positions
`define DBGX_ST_BP_LSB       0
`define DBGX_ST_GUARD_BIT    13
`define DBGX_ST_STEP_BIT     14
`define DBGX_ST_TASK_BIT     15
`define DBGX_ST_MASK         32'h0000E00F

// Control word field positions
`define DBGX_CTRL_GUARD_BIT  0
`define DBGX_CTRL_STEP_BIT   1
`define DBGX_CTRL_RESUME_BIT 2

// Breakpoint config word: per breakpoint i, local en at 2i, global en at 2i+1,
// usage at 16+4i, length at 18+4i
`define DBGX_CFG_LEN_LSB     18
`define DBGX_CFG_USE_LSB     16

// Usage and length encodings
`define DBGX_USE_EXEC        2'h0
`define DBGX_USE_WRITE       2'h1
`define DBGX_USE_RDWR        2'h3
`define DBGX_LEN_1           2'h0
`define DBGX_LEN_2           2'h1
`define DBGX_LEN_4           2'h3

// Exception vector
`define DBGX_VECTOR          8'h01

// Reset values
`define DBGX_RST_STATUS      32'h00000000
`define DBGX_RST_WORD        32'h00000000

// AXI responses
`define DBGX_RESP_OKAY       2'h0
`define DBGX_RESP_SLVERR     2'h2

`endif

// [src/dbgx_pkg.sv]
package dbgx_pkg;

  typedef enum logic [1:0]
  {
    DBGX_EXC_NONE,
    DBGX_EXC_FAULT,
    DBGX_EXC_TRAP
  } dbgx_kind_t;

endpackage

// [src/dbgx_bp_match.sv]
`timescale 1ns/1ps
`include "dbgx_map.svh"

module dbgx_bp_match
(
  input  wire logic [31:0] bp_addr,
  input  wire logic [1:0]  bp_length_field,
  input  wire logic [1:0]  bp_usage_field,
  input  wire logic        exec_valid,
  input  wire logic [31:0] exec_addr,
  input  wire logic        data_valid,
  input  wire logic        data_write,
  input  wire logic [31:0] data_addr,
  input  wire logic [2:0]  data_size,
  output wire logic        exec_hit,
  output wire logic        data_hit
);

  // ****************************************************************
  // Aligned field compare
  // ****************************************************************
  wire logic [31:0] field_lo;
  wire logic [32:0] field_hi;
  wire logic [32:0] acc_hi;
  wire logic        overlap;
  wire logic        use_ok;

  assign field_lo = (bp_length_field == `DBGX_LEN_4) ? {bp_addr[31:2], 2'h0} :
                    (bp_length_field == `DBGX_LEN_2) ? {bp_addr[31:1], 1'h0} : bp_addr;
  assign field_hi = {1'b0, field_lo} +
                    ((bp_length_field == `DBGX_LEN_4) ? 33'h000000004 :
                     (bp_length_field == `DBGX_LEN_2) ? 33'h000000002 : 33'h000000001);
  assign acc_hi   = {1'b0, data_addr} + {30'h00000000, data_size};
  assign overlap  = ({1'b0, data_addr} < field_hi) && (acc_hi > {1'b0, field_lo});
  assign use_ok   = (bp_usage_field == `DBGX_USE_RDWR) ||
                    ((bp_usage_field == `DBGX_USE_WRITE) && data_write);

  assign exec_hit = exec_valid && (bp_usage_field == `DBGX_USE_EXEC) && (exec_addr == bp_addr);
  assign data_hit = data_valid && use_ok && overlap && (data_size != 3'h0);

endmodule

// [src/dbgx_debug_exception_status.sv]
`timescale 1ns/1ps
`include "dbgx_map.svh"

// Notes on behaviour
// - Four hit flags, one per breakpoint, set when its address, length, usage match.
// - Enabled breakpoint match by global or local enable raises debug vector 1.
// - Execution breakpoints raise a fault; data breakpoints raise a trap after transfer.
// - On an enabled exec or data match, every breakpoint matching that same kind has its flag set, enabled or not.
// - Guarded debug-register access sets the guarded-access status flag.
// - Entering the handler for a guarded access clears the guard bit.
// - Single-step enable causes a trap that sets the single-step flag.
// - Switch into a task with debug trap bit sets the task-switch flag.
// - Task-switch debug trap is raised after switch, before the new task's first instruction.
// - Resume flag suppresses the execution breakpoint at the return address.
// - Hardware only sets status flags; software clears them before returning.
// - Data access matches when wholly or partly inside aligned 1, 2 or 4 byte field.

module dbgx_debug_exception_status
#(
  parameter int NUM_BP = 4
)
(
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic [11:0]          s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output wire logic                 s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output wire logic                 s_axi_wready,
  output wire logic [1:0]           s_axi_bresp,
  output wire logic                 s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [11:0]          s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output wire logic                 s_axi_arready,
  output wire logic [31:0]          s_axi_rdata,
  output wire logic [1:0]           s_axi_rresp,
  output wire logic                 s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  input  wire logic                 exec_valid,
  input  wire logic [31:0]          exec_addr,
  input  wire logic                 data_valid,
  input  wire logic                 data_write,
  input  wire logic [31:0]          data_addr,
  input  wire logic [2:0]           data_size,
  input  wire logic                 insn_retire,
  input  wire logic                 dreg_access,
  input  wire logic                 task_switch_done,
  input  wire logic                 task_debug_trap,
  output wire logic                 dbg_exc_valid,
  output wire logic [7:0]           dbg_exc_vector,
  output wire logic [1:0]           dbg_exc_kind,
  output wire logic                 dbg_reg_access_ok,
  output wire logic                 irq
);

  // ****************************************************************
  // State
  // ****************************************************************
  logic [31:0]       debug_status_reg;
  logic [31:0]       status_next;
  logic [3:0]        irq_stat_reg;
  logic [3:0]        irq_stat_next;
  logic [3:0]        irq_mask_reg;
  logic [2:0]        ctrl_reg;
  logic [2:0]        ctrl_next;
  logic [31:0]       bp_addr_reg [NUM_BP];
  logic [31:0]       bp_cfg_reg;
  logic              exc_valid_reg;
  logic [1:0]        exc_kind_reg;
  logic              step_pend_reg;
  logic              step_pend_next;
  logic [11:0]       awaddr_reg;
  logic              aw_full_reg;
  logic [31:0]       wdata_reg;
  logic [3:0]        wstrb_reg;
  logic              w_full_reg;
  logic              bvalid_reg;
  logic [1:0]        bresp_reg;
  logic              rvalid_reg;
  logic [31:0]       rdata_reg;
  logic [1:0]        rresp_reg;

  // ****************************************************************
  // Breakpoint matching
  // ****************************************************************
  wire logic [NUM_BP-1:0] exec_hit;
  wire logic [NUM_BP-1:0] data_hit;
  wire logic [NUM_BP-1:0] bp_enabled;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_BP; gi++)
    begin : g_bp
      assign bp_enabled[gi] = bp_cfg_reg[2*gi] | bp_cfg_reg[2*gi+1];
      dbgx_bp_match u_match
      (
        .bp_addr         (bp_addr_reg[gi]),
        .bp_length_field (bp_cfg_reg[`DBGX_CFG_LEN_LSB+4*gi +: 2]),
        .bp_usage_field  (bp_cfg_reg[`DBGX_CFG_USE_LSB+4*gi +: 2]),
        .exec_valid      (exec_valid),
        .exec_addr       (exec_addr),
        .data_valid      (data_valid),
        .data_write      (data_write),
        .data_addr       (data_addr),
        .data_size       (data_size),
        .exec_hit        (exec_hit[gi]),
        .data_hit        (data_hit[gi])
      );
    end
  endgenerate

  // ****************************************************************
  // Event decode
  // ****************************************************************
  wire logic [NUM_BP-1:0] exec_live;
  wire logic              guard_set;
  wire logic              guard_fault;
  wire logic              exec_fault;
  wire logic              data_trap;
  wire logic              step_trap;
  wire logic              task_trap;
  wire logic              any_fault;
  wire logic              any_trap;
  wire logic [NUM_BP-1:0] bp_set;
  wire logic [31:0]       event_bits;

  assign exec_live   = ctrl_reg[`DBGX_CTRL_RESUME_BIT] ? '0 : exec_hit;
  assign guard_set   = ctrl_reg[`DBGX_CTRL_GUARD_BIT];
  assign guard_fault = dreg_access && guard_set;
  assign exec_fault  = |(exec_live & bp_enabled);
  assign data_trap   = |(data_hit & bp_enabled);
  assign step_trap   = step_pend_reg && insn_retire;
  assign task_trap   = task_switch_done && task_debug_trap;
  assign any_fault   = exec_fault || guard_fault;
  assign any_trap    = data_trap || step_trap || task_trap;
  assign bp_set      = (exec_fault ? exec_live : '0) | (data_trap ? data_hit : '0);
  assign event_bits  = {16'h0000,
                        task_trap,
                        step_trap,
                        guard_fault,
                        9'h000,
                        bp_set};

  assign dbg_reg_access_ok = !guard_set;
  assign dbg_exc_valid     = exc_valid_reg;
  assign dbg_exc_vector    = `DBGX_VECTOR;
  assign dbg_exc_kind      = exc_kind_reg;

  // ****************************************************************
  // Register bus decode
  // ****************************************************************
  wire logic        wr_fire;
  wire logic        rd_fire;
  wire logic [11:0] bp_off;
  wire logic        wr_bp;
  wire logic        wr_hit;
  wire logic        rd_bp;
  wire logic        rd_hit;
  wire logic [31:0] wmask;
  wire logic [31:0] wval;
  wire logic [31:0] rd_word;
  wire logic [31:0] status_w;

  assign s_axi_awready = !aw_full_reg && !bvalid_reg;
  assign s_axi_wready  = !w_full_reg && !bvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;

  assign wr_fire  = aw_full_reg && w_full_reg && !bvalid_reg;
  assign rd_fire  = s_axi_arvalid && !rvalid_reg;
  assign bp_off   = awaddr_reg - `DBGX_OFF_BP_ADDR0;
  assign wr_bp    = (awaddr_reg >= `DBGX_OFF_BP_ADDR0) && (awaddr_reg < `DBGX_OFF_BP_CFG);
  assign wr_hit   = wr_bp || (awaddr_reg == `DBGX_OFF_STATUS) ||
                    (awaddr_reg == `DBGX_OFF_IRQ_STAT) || (awaddr_reg == `DBGX_OFF_IRQ_MASK) ||
                    (awaddr_reg == `DBGX_OFF_CTRL) || (awaddr_reg == `DBGX_OFF_BP_CFG) ||
                    (awaddr_reg == `DBGX_OFF_LAST_EXC);
  assign rd_bp    = (s_axi_araddr >= `DBGX_OFF_BP_ADDR0) && (s_axi_araddr < `DBGX_OFF_BP_CFG);
  assign wmask    = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}}, {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
  assign wval     = wdata_reg & wmask;
  assign status_w = (wr_fire && awaddr_reg == `DBGX_OFF_STATUS) ? wmask & ~wdata_reg : '0;
  assign rd_hit   = rd_bp || (s_axi_araddr == `DBGX_OFF_STATUS) ||
                    (s_axi_araddr == `DBGX_OFF_IRQ_STAT) ||
                    (s_axi_araddr == `DBGX_OFF_IRQ_MASK) ||
                    (s_axi_araddr == `DBGX_OFF_CTRL) || (s_axi_araddr == `DBGX_OFF_BP_CFG) ||
                    (s_axi_araddr == `DBGX_OFF_LAST_EXC);
  assign rd_word  = rd_bp ? bp_addr_reg[s_axi_araddr[3:2]] :
                    (s_axi_araddr == `DBGX_OFF_STATUS)   ? debug_status_reg :
                    (s_axi_araddr == `DBGX_OFF_IRQ_STAT) ? {28'h0000000, irq_stat_reg} :
                    (s_axi_araddr == `DBGX_OFF_IRQ_MASK) ? {28'h0000000, irq_mask_reg} :
                    (s_axi_araddr == `DBGX_OFF_CTRL)     ? {29'h0000000, ctrl_reg} :
                    (s_axi_araddr == `DBGX_OFF_BP_CFG)   ? bp_cfg_reg :
                    (s_axi_araddr == `DBGX_OFF_LAST_EXC) ? {30'h0000000, exc_kind_reg} :
                    32'h00000000;

  // ****************************************************************
  // Status, control and interrupt next state
  // ****************************************************************
  wire logic [3:0] irq_events;
  wire logic [3:0] irq_clear;

  assign irq_events = {task_trap, step_trap, guard_fault, |bp_set};
  assign irq_clear  = (wr_fire && awaddr_reg == `DBGX_OFF_IRQ_STAT) ? wval[3:0] : 4'h0;
  assign irq        = |(irq_stat_reg & irq_mask_reg);

  always_comb
  begin
    // Software clear by zero write, then hardware set wins
    status_next   = ((debug_status_reg & ~status_w) | event_bits) & `DBGX_ST_MASK;
    irq_stat_next = (irq_stat_reg & ~irq_clear) | irq_events;
    ctrl_next     = ctrl_reg;
    if (wr_fire && awaddr_reg == `DBGX_OFF_CTRL && wstrb_reg[0])
    begin
      ctrl_next = wdata_reg[2:0];
    end
    if (guard_fault)
    begin
      ctrl_next[`DBGX_CTRL_GUARD_BIT] = 1'b0;
    end
    if (exec_valid && ctrl_reg[`DBGX_CTRL_RESUME_BIT])
    begin
      ctrl_next[`DBGX_CTRL_RESUME_BIT] = 1'b0;
    end
    step_pend_next = step_pend_reg;
    if (exec_valid && !any_fault)
    begin
      step_pend_next = ctrl_reg[`DBGX_CTRL_STEP_BIT];
    end
    else if (insn_retire)
    begin
      step_pend_next = 1'b0;
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      debug_status_reg <= `DBGX_RST_STATUS;
      irq_stat_reg     <= 4'h0;
      ctrl_reg         <= 3'h0;
      step_pend_reg    <= 1'b0;
      exc_valid_reg    <= 1'b0;
      exc_kind_reg     <= dbgx_pkg::DBGX_EXC_NONE;
    end
    else
    begin
      debug_status_reg <= status_next;
      irq_stat_reg     <= irq_stat_next;
      ctrl_reg         <= ctrl_next;
      step_pend_reg    <= step_pend_next;
      exc_valid_reg    <= any_fault || any_trap;
      if (any_fault)
      begin
        exc_kind_reg <= dbgx_pkg::DBGX_EXC_FAULT;
      end
      else if (any_trap)
      begin
        exc_kind_reg <= dbgx_pkg::DBGX_EXC_TRAP;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_mask_reg <= 4'h0;
      bp_cfg_reg   <= `DBGX_RST_WORD;
      for (int i = 0; i < NUM_BP; i++)
      begin
        bp_addr_reg[i] <= `DBGX_RST_WORD;
      end
    end
    else if (wr_fire)
    begin
      if (awaddr_reg == `DBGX_OFF_IRQ_MASK)
      begin
        irq_mask_reg <= (irq_mask_reg & ~wmask[3:0]) | wval[3:0];
      end
      if (awaddr_reg == `DBGX_OFF_BP_CFG)
      begin
        bp_cfg_reg <= (bp_cfg_reg & ~wmask) | wval;
      end
      if (wr_bp)
      begin
        bp_addr_reg[bp_off[3:2]] <= (bp_addr_reg[bp_off[3:2]] & ~wmask) | wval;
      end
    end
  end

  // ****************************************************************
  // AXI4-Lite handshake
  // ****************************************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awaddr_reg  <= 12'h000;
      aw_full_reg <= 1'b0;
      wdata_reg   <= 32'h00000000;
      wstrb_reg   <= 4'h0;
      w_full_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `DBGX_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        awaddr_reg  <= {s_axi_awaddr[11:2], 2'h0};
        aw_full_reg <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
        w_full_reg <= 1'b1;
      end
      if (wr_fire)
      begin
        aw_full_reg <= 1'b0;
        w_full_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= wr_hit ? `DBGX_RESP_OKAY : `DBGX_RESP_SLVERR;
      end
      else if (bvalid_reg && s_axi_bready)
      begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h00000000;
      rresp_reg  <= `DBGX_RESP_OKAY;
    end
    else if (rd_fire)
    begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_word;
      rresp_reg  <= rd_hit ? `DBGX_RESP_OKAY : `DBGX_RESP_SLVERR;
    end
    else if (rvalid_reg && s_axi_rready)
    begin
      rvalid_reg <= 1'b0;
    end
  end

endmodule

// [sim/dbgx_debug_exception_status_assertions.sv]
`timescale 1ns/1ps
`include "dbgx_map.svh"

module dbgx_des_chk
#(
  parameter int NUM_BP = 4
)
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        exec_valid,
  input wire logic        data_valid,
  input wire logic        insn_retire,
  input wire logic        dreg_access,
  input wire logic        task_switch_done,
  input wire logic        task_debug_trap,
  input wire logic        dbg_exc_valid,
  input wire logic [7:0]  dbg_exc_vector,
  input wire logic [1:0]  dbg_exc_kind,
  input wire logic        dbg_reg_access_ok
);
  // ****************************************
  // Sequences
  // ****************************************
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_task;
    task_switch_done && task_debug_trap && !exec_valid && !dreg_access;
  endsequence
  sequence s_guard_hit;
    dreg_access && !dbg_reg_access_ok;
  endsequence
  sequence s_wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence

  // ****************************************
  // Assertions
  // ****************************************
  AST_VECTOR: assert property (dbg_exc_vector == `DBGX_VECTOR)
    else $error("debug vector wrong");
  AST_TASK_TRAP: assert property (s_task |=> dbg_exc_valid &&
    dbg_exc_kind == dbgx_pkg::DBGX_EXC_TRAP) else $error("task switch trap missing");
  AST_GUARD_CLR: assert property (s_guard_hit |=> dbg_reg_access_ok &&
    dbg_exc_valid && dbg_exc_kind == dbgx_pkg::DBGX_EXC_FAULT) else $error("guard fault bad");
  AST_EXC_CAUSE: assert property (dbg_exc_valid |-> $past(exec_valid) ||
    $past(data_valid) || $past(insn_retire) || $past(dreg_access) ||
    $past(task_switch_done)) else $error("exception without cause");
  AST_KIND_FAULT: assert property (dbg_exc_valid &&
    dbg_exc_kind == dbgx_pkg::DBGX_EXC_FAULT |-> $past(exec_valid) || $past(dreg_access))
    else $error("fault from wrong cause");
  AST_KIND_TRAP: assert property (dbg_exc_valid &&
    dbg_exc_kind == dbgx_pkg::DBGX_EXC_TRAP |-> $past(data_valid) || $past(insn_retire) ||
    $past(task_switch_done)) else $error("trap from wrong cause");
  AST_W_LAT: assert property (s_wr_both |=> ##1 s_axi_bvalid)
    else $error("write response late");
  AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
endmodule

bind dbgx_debug_exception_status dbgx_des_chk #(.NUM_BP(NUM_BP)) u_chk
(
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .exec_valid, .data_valid, .insn_retire,
  .dreg_access, .task_switch_done, .task_debug_trap, .dbg_exc_valid, .dbg_exc_vector,
  .dbg_exc_kind, .dbg_reg_access_ok
);

// [sim/dbgx_debug_exception_status_tb_top.sv]
`timescale 1ns/1ps
`include "dbgx_map.svh"

`define CHK(a, e) \
  begin \
    samples_checked++; \
    if ((a) !== (e)) \
    begin \
      errors++; \
      $display("BAD %0t got %h exp %h", $time, a, e); \
    end \
  end

module dbgx_debug_exception_status_tb_top;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, exec_valid, data_valid, data_write, insn_retire, irq;
  logic        dreg_access, task_switch_done, task_debug_trap, dbg_exc_valid;
  logic        dbg_reg_access_ok;
  logic [1:0]  s_axi_bresp, s_axi_rresp, dbg_exc_kind;
  logic [2:0]  data_size;
  logic [3:0]  s_axi_wstrb;
  logic [7:0]  dbg_exc_vector;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, exec_addr, data_addr;
  int          errors = 0;
  int          samples_checked = 0;

  always #2 aclk = ~aclk;

  dbgx_debug_exception_status #(.NUM_BP(4)) i_dut
  (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .exec_valid, .exec_addr, .data_valid,
    .data_write, .data_addr, .data_size, .insn_retire, .dreg_access, .task_switch_done,
    .task_debug_trap, .dbg_exc_valid, .dbg_exc_vector, .dbg_exc_kind,
    .dbg_reg_access_ok, .irq
  );

  // ****************************************
  // Tasks
  // ****************************************
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1)
        s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    `CHK(s_axi_bresp, er)
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1)
        s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    `CHK(s_axi_rdata, ed)
    `CHK(s_axi_rresp, er)
  endtask

  // Order: exec, data, retire, debug reg access, task switch, task trap bit
  task automatic pulse(input logic [5:0] p, input logic [31:0] a);
    @(posedge aclk);
    {exec_valid, data_valid, insn_retire, dreg_access, task_switch_done,
     task_debug_trap} <= p;
    exec_addr <= a;
    data_addr <= a;
  endtask

  task automatic fire(input logic ev, input logic [1:0] k);
    @(posedge aclk);
    {exec_valid, data_valid, insn_retire, dreg_access, task_switch_done,
     task_debug_trap} <= 6'h00;
    #1;
    `CHK(dbg_exc_valid, ev)
    if (ev)
      `CHK(dbg_exc_kind, k)
  endtask

  task automatic stop_test;
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ****************************************
  // Tests
  // ****************************************
  initial
  begin
    #40000;
    errors++;
    stop_test();
  end

  initial
  begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {exec_valid, data_valid, insn_retire, dreg_access, task_switch_done} = 5'h00;
    {task_debug_trap, data_write} = 2'h1;
    s_axi_awaddr = 12'h000;
    s_axi_araddr = 12'h000;
    s_axi_wdata = 32'h00000000;
    s_axi_wstrb = 4'hF;
    exec_addr = 32'h00000000;
    data_addr = 32'h00000000;
    data_size = 3'h1;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`DBGX_OFF_STATUS, `DBGX_RST_STATUS, `DBGX_RESP_OKAY);
    `CHK(dbg_exc_vector, `DBGX_VECTOR)
    `CHK(irq, 1'b0)
    $display("test reset done");
    wr(`DBGX_OFF_BP_ADDR0, 32'h00000200, `DBGX_RESP_OKAY);
    wr(`DBGX_OFF_BP_ADDR0 + 12'h004, 32'h00000100, `DBGX_RESP_OKAY);
    wr(`DBGX_OFF_BP_ADDR0 + 12'h008, 32'h00000102, `DBGX_RESP_OKAY);
    wr(`DBGX_OFF_BP_ADDR0 + 12'h00C, 32'h00000300, `DBGX_RESP_OKAY);
    wr(`DBGX_OFF_BP_CFG, 32'h17D00009, `DBGX_RESP_OKAY);
    data_write <= 1'b0;
    pulse(6'h10, 32'h00000103);
    fire(1'b0, 2'h0);
    data_write <= 1'b1;
    pulse(6'h10, 32'h00000104);
    fire(1'b0, 2'h0);
    pulse(6'h10, 32'h00000103);
    fire(1'b1, dbgx_pkg::DBGX_EXC_TRAP);
    rd(`DBGX_OFF_STATUS, 32'h00000006, `DBGX_RESP_OKAY);
    pulse(6'h20, 32'h00000200);
    fire(1'b1, dbgx_pkg::DBGX_EXC_FAULT);
    rd(`DBGX_OFF_STATUS, 32'h00000007, `DBGX_RESP_OKAY);
    wr(`DBGX_OFF_STATUS, 32'h00000000, `DBGX_RESP_OKAY);
    rd(`DBGX_OFF_STATUS, 32'h00000000, `DBGX_RESP_OKAY);
    $display("test breakpoints done");
    wr(`DBGX_OFF_CTRL, 32'h00000004, `DBGX_RESP_OKAY);
    pulse(6'h20, 32'h00000200);
    fire(1'b0, 2'h0);
    pulse(6'h20, 32'h00000200);
    fire(1'b1, dbgx_pkg::DBGX_EXC_FAULT);
    wr(`DBGX_OFF_STATUS, 32'h00000000, `DBGX_RESP_OKAY);
    $display("test resume done");
    wr(`DBGX_OFF_CTRL, 32'h00000001, `DBGX_RESP_OKAY);
    `CHK(dbg_reg_access_ok, 1'b0)
    pulse(6'h04, 32'h00000000);
    fire(1'b1, dbgx_pkg::DBGX_EXC_FAULT);
    `CHK(dbg_reg_access_ok, 1'b1)
    rd(`DBGX_OFF_STATUS, 32'h00002000, `DBGX_RESP_OKAY);
    rd(`DBGX_OFF_CTRL, 32'h00000000, `DBGX_RESP_OKAY);
    $display("test guard done");
    wr(`DBGX_OFF_STATUS, 32'h00000000, `DBGX_RESP_OKAY);
    wr(`DBGX_OFF_CTRL, 32'h00000002, `DBGX_RESP_OKAY);
    pulse(6'h20, 32'h00000204);
    fire(1'b0, 2'h0);
    pulse(6'h08, 32'h00000000);
    fire(1'b1, dbgx_pkg::DBGX_EXC_TRAP);
    rd(`DBGX_OFF_STATUS, 32'h00004000, `DBGX_RESP_OKAY);
    $display("test step done");
    wr(`DBGX_OFF_CTRL, 32'h00000000, `DBGX_RESP_OKAY);
    wr(`DBGX_OFF_STATUS, 32'h00000000, `DBGX_RESP_OKAY);
    pulse(6'h02, 32'h00000000);
    fire(1'b0, 2'h0);
    pulse(6'h03, 32'h00000000);
    fire(1'b1, dbgx_pkg::DBGX_EXC_TRAP);
    rd(`DBGX_OFF_STATUS, 32'h00008000, `DBGX_RESP_OKAY);
    $display("test task done");
    `CHK(irq, 1'b0)
    wr(`DBGX_OFF_IRQ_MASK, 32'h00000001, `DBGX_RESP_OKAY);
    `CHK(irq, 1'b1)
    rd(`DBGX_OFF_IRQ_STAT, 32'h0000000F, `DBGX_RESP_OKAY);
    wr(`DBGX_OFF_IRQ_STAT, 32'h0000000F, `DBGX_RESP_OKAY);
    `CHK(irq, 1'b0)
    rd(`DBGX_OFF_IRQ_STAT, 32'h00000000, `DBGX_RESP_OKAY);
    wr(12'h040, 32'hFFFFFFFF, `DBGX_RESP_SLVERR);
    rd(12'h040, 32'h00000000, `DBGX_RESP_SLVERR);
    $display("test irq done");
    stop_test();
  end
endmodule
